// *** fcq_defines.svh ***
/*
 * timing counts, command codes and query-table locations for the flash
 * command host. assumes a parallel nor flash behind cs/we/oe strobes, with
 * the host clock at 125 mhz.
 */
`ifndef FCQ_DEFINES_SVH
`define FCQ_DEFINES_SVH
// Overview of operation
// RQ1: device latches address late fall, data early rise
// RQ2: device powers up in read-array state
// RQ3: erase suspend gives erase-suspend-read state
// RQ4: host resets after timeout flag or autoselect
// RQ5: reset returns read or suspend-read, address ignored
// RQ6: reset aborts erase sequence before erasure only
// RQ7: reset aborts program sequence before programming only
// RQ8: reset leaves autoselect to read or suspend-read
// RQ9: reset after timeout flag restores read state
// RQ10: host sends buffer-abort reset after abort flag; fcq_host only raises recover_needed_out, the user must write it
// RQ11: autoselect only from read or suspend-read
// RQ12: three-cycle unlock enters autoselect, reads repeat
// RQ13: autoselect manufacturer code at offset zero
// RQ14: device code from three word addresses
// RQ15: sector protect status at sector plus 02h
// RQ16: host resets after bad sequence
// RQ17: query size, interface, write-size words
// RQ18: query reports one uniform erase region
// RQ19: extension table begins PRI, version 1.3
// RQ20: extension reports unlock, suspend, protect codes
// RQ21: extension reports page mode, accel supply codes
// RQ22: boot flag word 04h/05h, program suspend
// RQ23: query command 98h at 55h enters query
// RQ24: undefined query words read zero
// RQ25: customary unlock addresses and command codes
// bus timing, in ns, and derived 8 ns cycle counts (least times round up)
`define FCQ_CLK_NS 8
`define FCQ_T_SETUP_NS 40
`define FCQ_T_PULSE_NS 48
`define FCQ_T_ACCESS_NS 96
`define FCQ_SETUP_CYC ((`FCQ_T_SETUP_NS + `FCQ_CLK_NS - 1) / `FCQ_CLK_NS)
`define FCQ_PULSE_CYC ((`FCQ_T_PULSE_NS + `FCQ_CLK_NS - 1) / `FCQ_CLK_NS)
`define FCQ_ACCESS_CYC ((`FCQ_T_ACCESS_NS + `FCQ_CLK_NS - 1) / `FCQ_CLK_NS)
// command cycles
`define FCQ_UNLOCK1_ADDR 23'h00_0555
`define FCQ_UNLOCK1_DATA 16'h00AA
`define FCQ_UNLOCK2_ADDR 23'h00_02AA
`define FCQ_UNLOCK2_DATA 16'h0055
`define FCQ_AUTOSEL_DATA 16'h0090
`define FCQ_RESET_DATA 16'h00F0
`define FCQ_QUERY_ADDR 23'h00_0055
`define FCQ_QUERY_DATA 16'h0098
// autoselect locations
`define FCQ_AS_MFR 8'h00
`define FCQ_AS_DEV1 8'h01
`define FCQ_AS_DEV2 8'h0E
`define FCQ_AS_DEV3 8'h0F
`define FCQ_AS_PROT 8'h02
`define FCQ_PROT_YES 16'h0001
`define FCQ_PROT_NO 16'h0000
// query table locations and expected words
`define FCQ_Q_SIZE 8'h27
`define FCQ_Q_REGIONS 8'h2C
`define FCQ_Q_PRI 8'h40
`define FCQ_Q_BOOTFLAG 8'h4F
`define FCQ_BOOT_BOTTOM 16'h0004
`define FCQ_BOOT_TOP 16'h0005
`define FCQ_WORD_ADDR_W 23
`endif

// *** fcq_flash_model.sv ***
/* behavioural flash device: array, autoselect and query reads, unlock,
   query and reset commands. assumes active low strobes from the host. */
`timescale 1ns/10ps
`default_nettype none
module fcq_flash_model #(
    parameter logic [63:0] ID_WORDS = 64'h0000_0000_0000_0000, // arbitrary id words
    parameter int ACC_NS = 80, // slow answer, inside the 11 cycles of oe low
    parameter logic [15:0] SUSPEND_DATA = 16'h00E5 // arbitrary suspend command word
) (
    input wire logic [22:0] addr_in,
    input wire logic [15:0] dq_in,
    input wire logic cs_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    output logic [15:0] dq_out
);
    logic [1:0] mode = 2'h0; // 0 array, 1 autoselect, 2 query
    logic [1:0] unl = 2'h0; // unlock cycles seen
    logic [22:0] a_lat; // latched command address
    logic [15:0] last = 16'h0000; // last word shown
    logic [15:0] rd; // word the mode presents
    logic susp = 1'b0; // erase suspended, other sectors still read
    logic [7:0] susp_sec = 8'h00; // sector held in suspend
    wire logic wr_act = !we_n_in && !cs_n_in;
    // address on the later fall
    always @(posedge wr_act) a_lat = addr_in;
    // data on the earlier rise, then decode
    always @(negedge wr_act) begin
        // reset keeps susp, so it lands in suspend-read when suspended;
        // it also clears the unlock count below, aborting any sequence
        if (dq_in == 16'h00F0) mode = 2'h0;
        else if (dq_in == 16'h0098 && a_lat[7:0] == 8'h55) mode = 2'h2;
        else if (mode == 2'h0 && unl == 2'h2 && dq_in == 16'h0090) mode = 2'h1;
        else if (mode == 2'h0 && dq_in == SUSPEND_DATA) begin
            susp = 1'b1;
            susp_sec = a_lat[22:15];
        end
        unl = (mode == 2'h0 && dq_in == 16'h00AA && a_lat[10:0] == 11'h555) ? 2'h1 :
              (unl == 2'h1 && dq_in == 16'h0055 && a_lat[10:0] == 11'h2AA) ? 2'h2 : 2'h0;
    end
    // read word per mode; odd-numbered sectors (addr_in[15] set) count as guarded
    always_comb begin
        rd = 16'h0000;
        case ({mode, addr_in[7:0]})
            10'h100: rd = ID_WORDS[63:48];
            10'h101: rd = ID_WORDS[47:32];
            10'h10E: rd = ID_WORDS[31:16];
            10'h10F: rd = ID_WORDS[15:0];
            10'h102: rd = {15'h0000, addr_in[15]};
            10'h227: rd = 16'h0018;
            10'h228, 10'h246: rd = 16'h0002;
            10'h22A: rd = 16'h0005;
            10'h22C, 10'h230, 10'h247, 10'h248, 10'h24C, 10'h250: rd = 16'h0001;
            10'h22D: rd = 16'h00FF;
            10'h240: rd = 16'h0050;
            10'h241: rd = 16'h0052;
            10'h242: rd = 16'h0049;
            10'h243: rd = 16'h0031;
            10'h244: rd = 16'h0033;
            10'h245: rd = 16'h0008;
            10'h249, 10'h24F: rd = 16'h0004;
            10'h24D: rd = 16'h00B5;
            10'h24E: rd = 16'h00C5;
            // array pattern; the suspended sector is not served, reads all ones
            default: if (mode == 2'h0) begin
                rd = (susp && addr_in[22:15] == susp_sec) ? 16'hFFFF : addr_in[15:0] ^ 16'h5A5A;
            end
        endcase
    end
    // released bus shows the inverse, never a stale word
    assign #(ACC_NS) dq_out = (!cs_n_in && !oe_n_in) ? rd : ~last;
    always @(posedge oe_n_in) last = rd;
endmodule
`default_nettype wire

// *** fcq_host.sv ***
/*
 * host-side controller for a parallel nor flash command interpreter. it
 * turns user orders into strobe cycles: reads, single writes, the reset
 * command, the three-cycle autoselect entry and the query entry.
 * assumes the flash answers within the access time and that pins are
 * synchronous to clk_sys_in.
 */
`timescale 1ns/10ps
`include "fcq_defines.svh"
`default_nettype none
module fcq_host (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire fcq_pkg::fcq_req_s req_in,
    input wire logic timeout_flag_in,
    input wire logic buffer_abort_flag_in,
    input wire logic [15:0] flash_dq_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [15:0] rsp_data_out,
    output logic recover_needed_out,
    output logic [22:0] flash_addr_out,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe_out,
    output logic flash_cs_n_out,
    output logic flash_we_n_out,
    output logic flash_oe_n_out
);
    // bus cycle phases; a command sequence loops setup, pulse, hold
    // per cycle, while a read goes setup then access
    typedef enum logic [2:0] {
        ST_IDLE, // waiting for an order
        ST_SETUP, // cs low, address and data settling
        ST_PULSE, // write strobe low
        ST_HOLD, // strobes high between command cycles
        ST_RD, // output strobe low, waiting out the access time
        ST_DONE // one cycle to raise the answer pulse
    } fcq_state_e;
    fcq_state_e state_reg; // current phase
    logic [3:0] cnt_reg; // phase timer
    logic [1:0] seq_reg; // index of command cycle in a sequence
    logic [1:0] seq_len_reg; // cycles in current sequence minus one
    fcq_pkg::fcq_req_s cur_reg; // order being served
    logic is_read_reg; // order is a plain read, no write strobe

    // address of cycle n of a command sequence; unlock and command cycles
    // use fixed addresses so a user order cannot corrupt them
    function automatic logic [22:0] seq_addr(input fcq_pkg::fcq_req_s r, input logic [1:0] n);
        if (r.op == fcq_pkg::FCQ_OP_AUTOSEL && n == 2'd0) begin
            seq_addr = `FCQ_UNLOCK1_ADDR; // RQ25
        end else if (r.op == fcq_pkg::FCQ_OP_AUTOSEL && n == 2'd1) begin
            seq_addr = `FCQ_UNLOCK2_ADDR;
        end else if (r.op == fcq_pkg::FCQ_OP_AUTOSEL) begin
            seq_addr = `FCQ_UNLOCK1_ADDR; // RQ12
        end else if (r.op == fcq_pkg::FCQ_OP_QUERY) begin
            seq_addr = `FCQ_QUERY_ADDR; // RQ23
        end else if (r.op == fcq_pkg::FCQ_OP_RESET) begin
            seq_addr = 23'h00_0000; // RQ5
        end else begin
            seq_addr = r.addr;
        end
    endfunction

    // data of cycle n of a command sequence; only a raw write or read
    // passes the user's own word through
    function automatic logic [15:0] seq_data(input fcq_pkg::fcq_req_s r, input logic [1:0] n);
        if (r.op == fcq_pkg::FCQ_OP_AUTOSEL && n == 2'd0) begin
            seq_data = `FCQ_UNLOCK1_DATA;
        end else if (r.op == fcq_pkg::FCQ_OP_AUTOSEL && n == 2'd1) begin
            seq_data = `FCQ_UNLOCK2_DATA;
        end else if (r.op == fcq_pkg::FCQ_OP_AUTOSEL) begin
            seq_data = `FCQ_AUTOSEL_DATA;
        end else if (r.op == fcq_pkg::FCQ_OP_QUERY) begin
            seq_data = `FCQ_QUERY_DATA;
        end else if (r.op == fcq_pkg::FCQ_OP_RESET) begin
            seq_data = `FCQ_RESET_DATA; // RQ16
        end else begin
            seq_data = r.data;
        end
    endfunction

    // sequencer: setup, strobe pulse, hold, or read access; this process
    // alone owns phase, counter and sequence index, the others decode them
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            seq_reg <= 2'd0;
            seq_len_reg <= 2'd0;
            cur_reg <= '0;
            is_read_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    // orders start only from idle, so an autoselect entry
                    // never lands inside another command sequence
                    if (req_valid_in) begin // RQ11
                        // latch the whole order; req_in may change after
                        cur_reg <= req_in;
                        seq_reg <= 2'd0;
                        is_read_reg <= (req_in.op == fcq_pkg::FCQ_OP_READ);
                        // autoselect is three cycles, others one
                        seq_len_reg <= (req_in.op == fcq_pkg::FCQ_OP_AUTOSEL) ? 2'd2 : 2'd0;
                        cnt_reg <= 4'h0;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // address settles before the late falling strobe
                    if (cnt_reg == 4'(`FCQ_SETUP_CYC - 1)) begin
                        // setup time met: strobe the write or open the read
                        cnt_reg <= 4'h0;
                        state_reg <= is_read_reg ? ST_RD : ST_PULSE;
                    end else begin
                        // still settling
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                ST_PULSE: begin
                    // the last pulse cycle already has we high again, so
                    // the data edge comes while address and data still stand
                    if (cnt_reg == 4'(`FCQ_PULSE_CYC - 1)) begin
                        // pulse over: release cs next
                        cnt_reg <= 4'h0;
                        state_reg <= ST_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                ST_HOLD: begin
                    // one idle cycle between command cycles
                    if (seq_reg == seq_len_reg) begin
                        // last cycle of the sequence written
                        state_reg <= ST_DONE;
                    end else begin
                        // next command cycle of the sequence
                        seq_reg <= seq_reg + 2'd1;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_RD: begin
                    // oe is registered, so it falls one cycle into this
                    // phase; the flash has one cycle less than the count
                    if (cnt_reg == 4'(`FCQ_ACCESS_CYC - 1)) begin
                        // data sampled on this edge by the answer process
                        state_reg <= ST_DONE;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                ST_DONE: begin
                    // answer pulse goes out; ready returns a cycle later
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // pins: we rises before cs so data latches on we's early rise
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            flash_addr_out <= 23'h00_0000;
            flash_dq_out <= 16'h0000;
            flash_dq_oe_out <= 1'b0;
            flash_cs_n_out <= 1'b1;
            flash_we_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
        end else begin
            // address and data follow the order for its whole life, so
            // they stand across the strobe edges the flash latches on
            flash_addr_out <= seq_addr(cur_reg, seq_reg); // RQ1
            flash_dq_out <= seq_data(cur_reg, seq_reg);
            // drive the data bus only for writes; a read leaves it to the flash
            flash_dq_oe_out <= (state_reg == ST_SETUP && !is_read_reg) || state_reg == ST_PULSE;
            // cs covers setup, pulse and access, and is high in hold
            flash_cs_n_out <= !(state_reg == ST_SETUP || state_reg == ST_PULSE || state_reg == ST_RD);
            // we low only during pulse, cs already low: late fall is we
            flash_we_n_out <= !(state_reg == ST_PULSE && cnt_reg != 4'(`FCQ_PULSE_CYC - 1)); // RQ1
            // output strobe only in the access phase, never with we low
            flash_oe_n_out <= !(state_reg == ST_RD);
        end
    end

    // user answer side
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_data_out <= 16'h0000;
        end else begin
            // ready lags the state by a cycle; the user holds valid
            // until the answer pulse, so the lag costs nothing
            req_ready_out <= (state_reg == ST_IDLE) && !req_valid_in;
            // one pulse per order, reads and writes alike
            rsp_valid_out <= (state_reg == ST_DONE);
            // read data is held until the next read overwrites it
            if (state_reg == ST_RD && cnt_reg == 4'(`FCQ_ACCESS_CYC - 1)) begin
                rsp_data_out <= flash_dq_in; // RQ13 RQ17
            end
        end
    end

    // error flags mean the host must send a reset (or buffer-abort reset)
    // limitation: the buffer-abort reset sequence is not sent by this block;
    // the user must issue it as raw writes before the reset order
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            recover_needed_out <= 1'b0;
        end else if (timeout_flag_in || buffer_abort_flag_in) begin
            // set wins over a clear in the same cycle, so a flag that
            // rises during the reset order is not lost
            recover_needed_out <= 1'b1; // RQ4 RQ10
        end else if (state_reg == ST_DONE && cur_reg.op == fcq_pkg::FCQ_OP_RESET) begin
            // the reset order has been written to the flash
            recover_needed_out <= 1'b0; // RQ9
        end
    end
endmodule
`default_nettype wire

// *** fcq_host_monitor.sv ***
/* checker on the fcq_host ports: strobe shape, write hold, pulses, flags.
   assumes one clock domain and a bind from the bench. */
`timescale 1ns/10ps
`default_nettype none
module fcq_host_monitor (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic timeout_flag_in,
    input wire logic buffer_abort_flag_in,
    input wire logic rsp_valid_out,
    input wire logic recover_needed_out,
    input wire logic [22:0] flash_addr_out,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_dq_oe_out,
    input wire logic flash_cs_n_out,
    input wire logic flash_we_n_out,
    input wire logic flash_oe_n_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // write strobe low five cycles, then released
    sequence we_low_s;
        (!flash_we_n_out)[*5] ##1 flash_we_n_out;
    endsequence
    we_pulse_len_a: assert property ($fell(flash_we_n_out) |-> we_low_s) else $error("write pulse length");
    write_gate_a: assert property (!flash_we_n_out |-> !flash_cs_n_out && flash_oe_n_out && flash_dq_oe_out)
        else $error("write cycle gating");
    // the device latches late, so address and data must not move mid pulse
    write_hold_a: assert property (!flash_we_n_out && !$fell(flash_we_n_out) |-> $stable(flash_addr_out)
        && $stable(flash_dq_out)) else $error("write values moved");
    cs_release_a: assert property ($rose(flash_cs_n_out) |-> flash_we_n_out) else $error("cs rose first");
    read_gate_a: assert property (!flash_oe_n_out |-> !flash_cs_n_out && !flash_dq_oe_out)
        else $error("read cycle gating");
    rsp_pulse_a: assert property (rsp_valid_out |-> flash_we_n_out ##1 !rsp_valid_out)
        else $error("answer pulse");
    flag_sticky_a: assert property (timeout_flag_in || buffer_abort_flag_in |=> recover_needed_out)
        else $error("flag not kept");
    reset_idle_a: assert property ($fell(rst_in) |-> flash_cs_n_out && flash_we_n_out && flash_oe_n_out
        && !flash_dq_oe_out) else $error("bus busy after reset");
endmodule
`default_nettype wire

// *** fcq_pkg.sv ***
/*
 * types for the flash command host: user order codes and user order record.
 * assumes fcq_defines.svh supplies all numbers.
 */
package fcq_pkg;
    // orders taken at the user port
    typedef enum logic [2:0] {
        FCQ_OP_READ,
        FCQ_OP_RESET,
        FCQ_OP_AUTOSEL,
        FCQ_OP_QUERY,
        FCQ_OP_WRITE
    } fcq_op_e;
    // one user order
    typedef struct packed {
        fcq_op_e op;
        logic [22:0] addr;
        logic [15:0] data;
    } fcq_req_s;
endpackage

// *** tb_fcq_host.sv ***
/* self-checking bench for fcq_host with the flash model on its pins.
   assumes one rsp_valid_out pulse per order. */
`timescale 1ns/10ps
`default_nettype none
module tb_fcq_host;
    localparam logic [63:0] IDS = 64'h0A5C_0B01_0B02_0B03; // arbitrary
    localparam logic [15:0] SUSP = 16'h00E5; // arbitrary suspend command word
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic timeout_flag_in = 1'b0;
    logic buffer_abort_flag_in = 1'b0;
    fcq_pkg::fcq_req_s req_in = '0;
    wire logic [15:0] flash_dq_in;
    logic req_ready_out, rsp_valid_out, recover_needed_out, flash_dq_oe_out;
    logic flash_cs_n_out, flash_we_n_out, flash_oe_n_out;
    logic [15:0] rsp_data_out, flash_dq_out;
    logic [22:0] flash_addr_out;
    logic [16:0] exp_q[$]; // compare flag and word
    logic [16:0] e;
    int err_total = 0;
    int checks_done = 0;
    // query words at their word addresses
    logic [23:0] qt[20] = '{24'h27_0018, 24'h28_0002, 24'h2A_0005, 24'h2C_0001, 24'h2D_00FF, 24'h30_0001,
        24'h34_0000, 24'h40_0050, 24'h42_0049, 24'h44_0033, 24'h45_0008, 24'h46_0002, 24'h49_0004,
        24'h4A_0000, 24'h4C_0001, 24'h4D_00B5, 24'h4E_00C5, 24'h4F_0004, 24'h50_0001, 24'h5A_0000};
    fcq_host fcq_host_i (.clk_sys_in, .rst_in, .req_valid_in, .req_in, .timeout_flag_in,
        .buffer_abort_flag_in, .flash_dq_in, .req_ready_out, .rsp_valid_out, .rsp_data_out,
        .recover_needed_out, .flash_addr_out, .flash_dq_out, .flash_dq_oe_out, .flash_cs_n_out,
        .flash_we_n_out, .flash_oe_n_out);
    // access below the 11 cycles for which the host really holds oe low
    fcq_flash_model #(.ID_WORDS(IDS), .ACC_NS(80), .SUSPEND_DATA(SUSP)) fcq_flash_model_i (
        .addr_in(flash_addr_out),
        .dq_in(flash_dq_out), .cs_n_in(flash_cs_n_out), .we_n_in(flash_we_n_out),
        .oe_n_in(flash_oe_n_out), .dq_out(flash_dq_in));
    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            err_total++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one order, held until its answer pulse
    task automatic op(input fcq_pkg::fcq_op_e o, input logic [22:0] a, input logic [15:0] d, input logic [16:0] x);
        int n = 0;
        exp_q.push_back(x);
        @(negedge clk_sys_in);
        check({15'h0000, req_ready_out}, 16'h0001);
        req_in = '{o, a, d};
        req_valid_in = 1'b1;
        while (rsp_valid_out !== 1'b1 && n < 300) begin
            @(negedge clk_sys_in);
            n++;
        end
        req_valid_in = 1'b0;
        if (n == 300) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic rd(input logic [22:0] a, input logic [15:0] w);
        op(fcq_pkg::FCQ_OP_READ, a, 16'h0000, {1'b1, w});
    endtask
    // answers are matched oldest first, half a cycle after the pulse rises
    always @(negedge clk_sys_in) begin
        if (rsp_valid_out === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[16]) check(rsp_data_out, e[15:0]);
        end
    end
    initial begin
        logic [22:0] a;
        int i;
        i = $urandom(27126);
        repeat (4) @(negedge clk_sys_in);
        rst_in = 1'b0;
        a = 23'($urandom);
        rd(a, a[15:0] ^ 16'h5A5A);
        op(fcq_pkg::FCQ_OP_AUTOSEL, 23'h00_0000, 16'h0000, '0);
        rd(23'h00_3B00, IDS[63:48]);
        rd(23'h00_0001, IDS[47:32]);
        rd(23'h00_000E, IDS[31:16]);
        rd(23'h00_000F, IDS[15:0]);
        rd(23'h00_8002, 16'h0001);
        rd(23'h00_0002, 16'h0000);
        op(fcq_pkg::FCQ_OP_RESET, 23'($urandom), 16'h0000, '0);
        rd(a, a[15:0] ^ 16'h5A5A);
        $display("test autoselect done");
        op(fcq_pkg::FCQ_OP_AUTOSEL, 23'h00_0000, 16'h0000, '0);
        op(fcq_pkg::FCQ_OP_QUERY, 23'h00_0055, 16'h0098, '0);
        foreach (qt[k]) rd({15'h0000, qt[k][23:16]}, qt[k][15:0]);
        op(fcq_pkg::FCQ_OP_RESET, 23'h00_0000, 16'h0000, '0);
        op(fcq_pkg::FCQ_OP_WRITE, 23'h00_0555, 16'h00AA, '0);
        op(fcq_pkg::FCQ_OP_RESET, 23'h00_0000, 16'h0000, '0);
        op(fcq_pkg::FCQ_OP_WRITE, 23'h00_02AA, 16'h0055, '0);
        op(fcq_pkg::FCQ_OP_WRITE, 23'h00_0555, 16'h0090, '0);
        rd(23'h00_0000, 16'h5A5A);
        $display("test query and abort done");
        // suspend an upper-half sector; lower sectors keep reading
        op(fcq_pkg::FCQ_OP_WRITE, 23'h40_0000, SUSP, '0);
        a = {1'b0, 22'($urandom)};
        rd(a, a[15:0] ^ 16'h5A5A);
        op(fcq_pkg::FCQ_OP_AUTOSEL, 23'h00_0000, 16'h0000, '0);
        rd(23'h00_0000, IDS[63:48]);
        op(fcq_pkg::FCQ_OP_RESET, 23'h00_0000, 16'h0000, '0);
        rd(a ^ 23'h00_0101, a[15:0] ^ 16'h0101 ^ 16'h5A5A);
        $display("test suspend done");
        for (i = 1; i < 3; i++) begin
            {buffer_abort_flag_in, timeout_flag_in} = 2'(i);
            @(negedge clk_sys_in);
            {buffer_abort_flag_in, timeout_flag_in} = 2'h0;
            @(negedge clk_sys_in);
            check({15'h0000, recover_needed_out}, 16'h0001);
            op(fcq_pkg::FCQ_OP_RESET, 23'h00_0000, 16'h0000, '0);
            @(negedge clk_sys_in);
            check({15'h0000, recover_needed_out}, 16'h0000);
        end
        $display("test flags done");
        tally_and_finish();
    end
endmodule
bind fcq_host fcq_host_monitor fcq_host_monitor_i (.clk_sys_in, .rst_in, .timeout_flag_in,
    .buffer_abort_flag_in, .rsp_valid_out, .recover_needed_out, .flash_addr_out, .flash_dq_out,
    .flash_dq_oe_out, .flash_cs_n_out, .flash_we_n_out, .flash_oe_n_out);
`default_nettype wire
